// file: design/ssu_consts.svh
/*
 * Register indices, byte addresses, field positions, reset values and timing
 * limits of the clocked serial unit.
 * Assumes a 32-bit APB address where each register takes one aligned word.
 */
`ifndef SSU_CONSTS_SVH
`define SSU_CONSTS_SVH

// Register indices; the byte address of each is four times its index.
`define SSU_IDX_MAIN_CTL 28'hffffd00
`define SSU_IDX_CLK_CTL 28'hffffd01
`define SSU_IDX_LEN_CTL 28'hffffd02
`define SSU_IDX_STATUS 28'hffffd03
`define SSU_IDX_TX_DATA 28'hffffd04
`define SSU_IDX_RX_DATA 28'hffffd05

`define SSU_ADDR_MAIN_CTL {2'b00, `SSU_IDX_MAIN_CTL, 2'b00}
`define SSU_ADDR_CLK_CTL {2'b00, `SSU_IDX_CLK_CTL, 2'b00}
`define SSU_ADDR_LEN_CTL {2'b00, `SSU_IDX_LEN_CTL, 2'b00}
`define SSU_ADDR_STATUS {2'b00, `SSU_IDX_STATUS, 2'b00}
`define SSU_ADDR_TX_DATA {2'b00, `SSU_IDX_TX_DATA, 2'b00}
`define SSU_ADDR_RX_DATA {2'b00, `SSU_IDX_RX_DATA, 2'b00}

// Main control fields.
`define SSU_MC_PWR 7
`define SSU_MC_TXE 6
`define SSU_MC_RXE 5
`define SSU_MC_DIR 4
`define SSU_MC_TMS 1
`define SSU_MC_SCE 0
`define SSU_MC_MASK 8'hf3

// Status fields.
`define SSU_ST_BUSY 7
`define SSU_ST_OVF 0

// Length code fields.
`define SSU_LEN_TOP 3

// Reset values.
`define SSU_RST_MAIN_CTL 8'h00
`define SSU_RST_CLK_CTL 3'h0
`define SSU_RST_LEN_CTL 4'h0
`define SSU_RST_DATA 16'h0000

// Frame lengths in bits.
`define SSU_LEN_MIN 5'h08
`define SSU_LEN_MAX 5'h10

// Largest divider select; half a shift clock period is 2**sel pclk cycles.
`define SSU_DIV_SEL_MAX 3'h5

`endif

// file: design/ssu_pkg.sv
/*
 * Types shared by the clocked serial unit.
 * Assumes ssu_consts.svh for all numeric constants.
 */
package ssu_pkg;

    typedef enum logic [1:0] {
        SSU_IDLE,
        SSU_LOW,
        SSU_HIGH
    } ssu_state_t;

    typedef enum logic [2:0] {
        SSU_REG_MAIN,
        SSU_REG_CLK,
        SSU_REG_LEN,
        SSU_REG_STAT,
        SSU_REG_TX,
        SSU_REG_RX,
        SSU_REG_NONE
    } ssu_reg_t;

endpackage

// file: design/ssu_top.sv
/*
 * Clocked synchronous serial unit, master side: APB register file, frame
 * length decode, busy and overrun status, single and continuous transfers,
 * receive-complete and transmit-ready request pulses.
 * Assumes pclk at 20 MHz, presetn asynchronous active low, and a peer that
 * samples on the rising shift clock edge with the clock idling high.
 */
//
// Behaviour
// - Length code 0000 gives 8 bits, 0001-0111 give 9-15, top bit set gives 16.
// - Short frames use the low end of the data registers in either bit order.
// - Unused upper receive bits read zero after a short transfer.
// - Status resets to 00H and again whenever unit enable is cleared.
// - Busy is read-only, set by a transmit write or a receive dummy read.
// - Busy clears at the last shift clock edge of the frame.
// - Overrun sets when a reception completes before the previous word was read.
// - Overrun detection also applies in single mode, transmit only included.
// - Writing 0 clears overrun; writing 1 does nothing.
// - Two requests: receive-complete has priority over transmit-ready.
// - Receive-complete pulses whenever a word enters the receive register.
// - Receive-complete also pulses when an overrun occurs.
// - In single mode receive-complete pulses after every transfer.
// - Continuous transmit modes pulse transmit-ready once transmit data is taken.
// - Single modes never pulse transmit-ready.
// - Single transmit: a transmit write sets busy and starts a transfer.
// - During transmission the shift clock is driven and data shifted out with it.
// - After transmission clock and data stop, receive-complete pulses, busy clears.
// - Single receive: a dummy read sets busy, starts clocking and sampling input.
// - After reception clock and sampling stop, receive-complete pulses, busy clears.
// - A receive read restarts reception only while the start trigger is 1.
// - Serial output is held low while transmit enable is 0.
// - Bit order 0 shifts MSB first, 1 shifts LSB first.
`timescale 1ns/1ps
`include "ssu_consts.svh"

module ssu_top import ssu_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic shift_clock_pin,
    output logic serial_out_pin,
    input wire logic serial_in_pin,
    output logic receive_complete_irq,
    output logic transmit_ready_irq
);

    function automatic ssu_reg_t addr_decode(input logic [31:0] a);
        ssu_reg_t r;
        r = SSU_REG_NONE;
        case (a)
            `SSU_ADDR_MAIN_CTL: r = SSU_REG_MAIN;
            `SSU_ADDR_CLK_CTL: r = SSU_REG_CLK;
            `SSU_ADDR_LEN_CTL: r = SSU_REG_LEN;
            `SSU_ADDR_STATUS: r = SSU_REG_STAT;
            `SSU_ADDR_TX_DATA: r = SSU_REG_TX;
            `SSU_ADDR_RX_DATA: r = SSU_REG_RX;
            default: r = SSU_REG_NONE;
        endcase
        return r;
    endfunction

    function automatic logic [4:0] frame_len(input logic [3:0] code);
        logic [4:0] n;
        n = code[`SSU_LEN_TOP] ? `SSU_LEN_MAX : (`SSU_LEN_MIN + {2'b00, code[2:0]});
        return n;
    endfunction

    // Bit position of the cnt-th bit on the wire, always within the low length bits.
    function automatic logic [3:0] bit_pos(input logic [4:0] cnt, input logic [4:0] len,
                                           input logic lsb_first);
        logic [4:0] p;
        p = lsb_first ? cnt : (len - 5'h01 - cnt);
        return p[3:0];
    endfunction

    function automatic logic [5:0] div_half(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > `SSU_DIV_SEL_MAX) ? `SSU_DIV_SEL_MAX : sel;
        return 6'h01 << s;
    endfunction

    logic [7:0] ctl_q;
    logic [2:0] clk_sel_q;
    logic [3:0] len_code_q;
    logic busy_q;
    logic ovf_q;
    logic unread_q;
    logic [15:0] tx_q;
    logic tx_full_q;
    logic [15:0] rx_q;
    logic [15:0] sh_tx_q;
    logic [15:0] sh_rx_q;
    logic [4:0] cnt_q;
    logic [5:0] div_q;
    ssu_state_t state_q;
    logic go_q;
    logic next_q;
    logic sin_m1_q;
    logic sin_m2_q;
    logic sin_m3_q;
    logic sin_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic sck_q;
    logic sout_q;
    logic rx_irq_q;
    logic tx_irq_q;

    wire unit_enable = ctl_q[`SSU_MC_PWR];
    wire transmit_enable = ctl_q[`SSU_MC_TXE];
    wire receive_enable = ctl_q[`SSU_MC_RXE];
    wire bit_order_select = ctl_q[`SSU_MC_DIR];
    wire continuous = ctl_q[`SSU_MC_TMS];
    wire start_trigger_enable = ctl_q[`SSU_MC_SCE];

    wire setup = psel & ~penable;
    wire access = psel & penable & pready_q;
    ssu_reg_t acc_reg;
    assign acc_reg = addr_decode(paddr);
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire wr_main = wr & (acc_reg == SSU_REG_MAIN);
    wire wr_clk = wr & (acc_reg == SSU_REG_CLK);
    wire wr_len = wr & (acc_reg == SSU_REG_LEN);
    wire wr_stat = wr & (acc_reg == SSU_REG_STAT);
    wire wr_tx = wr & (acc_reg == SSU_REG_TX);
    wire rd_rx = rd & (acc_reg == SSU_REG_RX);

    wire [4:0] len = frame_len(len_code_q);
    wire [5:0] half = div_half(clk_sel_q);
    wire half_hit = (div_q == (half - 6'h01));
    wire last_bit = (cnt_q == (len - 5'h01));
    wire [3:0] pos = bit_pos(cnt_q, len, bit_order_select);
    wire [3:0] pos_next = bit_pos(cnt_q + 5'h01, len, bit_order_select);

    // A transmit write is taken when idle, or in continuous mode while the buffer is free.
    wire tx_accept = wr_tx & unit_enable & transmit_enable
                     & (~busy_q | (continuous & ~tx_full_q));
    wire start_tx = wr_tx & unit_enable & transmit_enable & ~busy_q;
    wire start_rd = rd_rx & unit_enable & receive_enable & ~transmit_enable
                    & start_trigger_enable & ~busy_q;

    wire done = (state_q == SSU_LOW) & half_hit & last_bit;
    wire cont = continuous & ((transmit_enable & tx_full_q)
                | (~transmit_enable & receive_enable & start_trigger_enable));
    wire load = ((state_q == SSU_IDLE) & go_q)
                | ((state_q == SSU_HIGH) & half_hit & next_q);
    wire [15:0] rx_word = sh_rx_q | ({15'h0, sin_q} << pos);
    // Single mode counts every frame as received; continuous only with reception on.
    wire capture = done & (receive_enable | ~continuous);

    // APB slave: one wait-free access phase after each setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & (acc_reg == SSU_REG_NONE);
            if (setup) begin
                case (acc_reg)
                    SSU_REG_MAIN: prdata_q <= {24'h000000, ctl_q};
                    SSU_REG_CLK: prdata_q <= {29'h0, clk_sel_q};
                    SSU_REG_LEN: prdata_q <= {28'h0000000, len_code_q};
                    SSU_REG_STAT: prdata_q <= {24'h000000, busy_q, 6'h00, ovf_q};
                    SSU_REG_TX: prdata_q <= {16'h0000, tx_q};
                    SSU_REG_RX: prdata_q <= {16'h0000, rx_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Mode bits are frozen while the unit runs; only enable and start trigger move.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= `SSU_RST_MAIN_CTL;
        end else if (wr_main) begin
            if (!unit_enable) begin
                ctl_q <= pwdata[7:0] & `SSU_MC_MASK;
            end else begin
                ctl_q[`SSU_MC_PWR] <= pwdata[`SSU_MC_PWR];
                ctl_q[`SSU_MC_SCE] <= pwdata[`SSU_MC_SCE];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel_q <= `SSU_RST_CLK_CTL;
        end else if (wr_clk && !unit_enable) begin
            clk_sel_q <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_code_q <= `SSU_RST_LEN_CTL;
        end else if (wr_len && (!unit_enable || (!transmit_enable && !receive_enable))) begin
            len_code_q <= pwdata[3:0];
        end
    end

    // Busy: set by a start, cleared at the last edge unless the next frame follows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else if (!unit_enable) begin
            busy_q <= 1'b0;
        end else if (start_tx || start_rd) begin
            busy_q <= 1'b1;
        end else if (done && !cont) begin
            busy_q <= 1'b0;
        end
    end

    // Overrun: a capture while the last word is unread sets it and wins over a clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else if (!unit_enable) begin
            ovf_q <= 1'b0;
        end else if (capture && unread_q) begin
            ovf_q <= 1'b1;
        end else if (wr_stat && !pwdata[`SSU_ST_OVF]) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unread_q <= 1'b0;
        end else if (!unit_enable) begin
            unread_q <= 1'b0;
        end else if (capture) begin
            unread_q <= 1'b1;
        end else if (rd_rx) begin
            unread_q <= 1'b0;
        end
    end

    // Transmit data and its buffer-full flag; the shifter takes a copy on load.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_q <= `SSU_RST_DATA;
            tx_full_q <= 1'b0;
        end else if (!unit_enable) begin
            tx_full_q <= 1'b0;
        end else if (tx_accept) begin
            tx_q <= pwdata[15:0];
            tx_full_q <= 1'b1;
        end else if (load) begin
            tx_full_q <= 1'b0;
        end
    end

    // Receive data is only replaced while reception is enabled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_q <= `SSU_RST_DATA;
        end else if (done && receive_enable) begin
            rx_q <= rx_word;
        end
    end

    // Busy drops at the last rise while the clock still idles out its high half, so a
    // start taken then is held here until the engine is back in idle and loads it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_q <= 1'b0;
        end else if (!unit_enable) begin
            go_q <= 1'b0;
        end else if (start_tx || start_rd) begin
            go_q <= 1'b1;
        end else if (load) begin
            go_q <= 1'b0;
        end
    end

    // Serial input synchroniser; a change counts once the last two stages agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sin_m1_q <= 1'b0;
            sin_m2_q <= 1'b0;
            sin_m3_q <= 1'b0;
            sin_q <= 1'b0;
        end else begin
            sin_m1_q <= serial_in_pin;
            sin_m2_q <= sin_m1_q;
            sin_m3_q <= sin_m2_q;
            if (sin_m2_q == sin_m3_q) begin
                sin_q <= sin_m3_q;
            end
        end
    end

    // Shift engine: clock low half drives data, rising edge samples input.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SSU_IDLE;
            sh_tx_q <= `SSU_RST_DATA;
            sh_rx_q <= `SSU_RST_DATA;
            cnt_q <= 5'h00;
            div_q <= 6'h00;
            next_q <= 1'b0;
            sck_q <= 1'b1;
            sout_q <= 1'b0;
        end else if (!unit_enable) begin
            state_q <= SSU_IDLE;
            next_q <= 1'b0;
            sck_q <= 1'b1;
            sout_q <= 1'b0;
        end else if (load) begin
            sh_tx_q <= transmit_enable ? tx_q : `SSU_RST_DATA;
            sh_rx_q <= `SSU_RST_DATA;
            cnt_q <= 5'h00;
            div_q <= 6'h00;
            next_q <= 1'b0;
            sck_q <= 1'b0;
            sout_q <= transmit_enable & tx_q[bit_pos(5'h00, len, bit_order_select)];
            state_q <= SSU_LOW;
        end else begin
            case (state_q)
                SSU_IDLE: begin
                    sck_q <= 1'b1;
                    sout_q <= 1'b0;
                end
                SSU_LOW: begin
                    if (half_hit) begin
                        div_q <= 6'h00;
                        sck_q <= 1'b1;
                        sh_rx_q <= rx_word;
                        next_q <= last_bit & cont;
                        state_q <= SSU_HIGH;
                    end else begin
                        div_q <= div_q + 6'h01;
                    end
                end
                SSU_HIGH: begin
                    if (!half_hit) begin
                        div_q <= div_q + 6'h01;
                    end else if (last_bit) begin
                        // Frame over without follower: clock parks high, data low.
                        div_q <= 6'h00;
                        sout_q <= 1'b0;
                        state_q <= SSU_IDLE;
                    end else begin
                        div_q <= 6'h00;
                        cnt_q <= cnt_q + 5'h01;
                        sck_q <= 1'b0;
                        sout_q <= transmit_enable & sh_tx_q[pos_next];
                        state_q <= SSU_LOW;
                    end
                end
                default: begin
                    state_q <= SSU_IDLE;
                    sck_q <= 1'b1;
                    sout_q <= 1'b0;
                end
            endcase
        end
    end

    // Request pulses; receive-complete comes before transmit-ready in priority.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_irq_q <= 1'b0;
            tx_irq_q <= 1'b0;
        end else begin
            rx_irq_q <= capture & unit_enable;
            tx_irq_q <= load & continuous & transmit_enable & unit_enable;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign shift_clock_pin = sck_q;
    assign serial_out_pin = sout_q;
    assign receive_complete_irq = rx_irq_q;
    assign transmit_ready_irq = tx_irq_q;

endmodule

// file: tb/ssu_top_sva.sv
/*
 * Port checker for ssu_top: APB timing, request pulses and shift clock framing.
 * Assumes one pclk domain with presetn asynchronous active low.
 */
`timescale 1ns/1ps
module ssu_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic shift_clock_pin,
    input wire logic serial_out_pin,
    input wire logic receive_complete_irq,
    input wire logic transmit_ready_irq
);
    logic sck_q;
    logic [5:0] hi_q;
    logic [4:0] rise_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q <= 1'b1;
            hi_q <= 6'h00;
        end else begin
            sck_q <= shift_clock_pin;
            hi_q <= !shift_clock_pin ? 6'h00 : (hi_q == 6'h3f ? hi_q : hi_q + 6'h01);
        end
    end
    // Rising shift clock edges since the last receive-complete request or the last long idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_q <= 5'h00;
        end else if (receive_complete_irq || hi_q > 6'h28) begin
            rise_q <= 5'h00;
        end else if (shift_clock_pin && !sck_q) begin
            rise_q <= rise_q + 5'h01;
        end
    end
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready missing after setup");
    property p_rdy_src; pready |-> $past(psel && !penable); endproperty
    a_rdy_src: assert property (p_rdy_src) else $error("pready without setup");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_err_data; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("refused read data not zero");
    property p_rc_pulse; receive_complete_irq |=> !receive_complete_irq; endproperty
    a_rc_pulse: assert property (p_rc_pulse) else $error("rx request too long");
    property p_rc_edge;
        receive_complete_irq |-> shift_clock_pin && !$past(shift_clock_pin);
    endproperty
    a_rc_edge: assert property (p_rc_edge) else $error("rx request off edge");
    // The last rise is seen in the request's own cycle, so the tally still lacks it.
    property p_frame;
        receive_complete_irq |-> rise_q >= 5'h07 && rise_q <= 5'h0f
            && shift_clock_pin && !sck_q;
    endproperty
    a_frame: assert property (p_frame) else $error("frame bit count wrong");
    property p_sout_chg; $rose(serial_out_pin) |-> $fell(shift_clock_pin); endproperty
    a_sout_chg: assert property (p_sout_chg) else $error("data rose off clock");
    property p_idle; hi_q > 6'h28 |-> !serial_out_pin; endproperty
    a_idle: assert property (p_idle) else $error("serial out high while idle");
    property p_tr_pulse; transmit_ready_irq |=> !transmit_ready_irq; endproperty
    a_tr_pulse: assert property (p_tr_pulse) else $error("tx request too long");
    c_rc: cover property (receive_complete_irq);
    c_tr: cover property (transmit_ready_irq);
    c_err: cover property (pslverr);
endmodule

// file: tb/ssu_peer.sv
/*
 * Serial peer: sends pat from bit 15 down on falling shift clock, captures
 * serial out on rising edges; after its hold time the data line toggles.
 * Assumes the master clock idles high.
 */
`timescale 1ns/1ps
module ssu_peer (
    input wire logic pclk,
    input wire logic sck,
    input wire logic sout,
    input wire logic clr,
    input wire logic [15:0] pat,
    output logic sin,
    output logic [15:0] got
);
    logic prev = 1'b1;
    logic [3:0] idx = 4'hf;
    int hold = -1;
    initial sin = 1'b0;
    initial got = 16'h0;
    always @(posedge pclk) begin
        prev <= sck;
        if (clr) begin
            idx <= 4'hf;
        end else if (prev && !sck) begin
            sin <= pat[idx];
            idx <= idx - 4'h1;
            hold <= -1;
        end else if (!prev && sck) begin
            got <= {got[14:0], sout};
            hold <= 5;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else if (hold == 0) begin
            sin <= ~sin;
        end
    end
endmodule

// file: tb/clocked_serial_length_status_bench.sv
/*
 * Bench for ssu_top: APB master, table of single transfers, hand-written cases.
 * Assumes ssu_peer on the serial pins and the checker bound at the foot.
 */
`timescale 1ns/1ps
`include "ssu_consts.svh"
module clocked_serial_length_status_bench;
    import ssu_pkg::*;
    typedef struct packed {logic [3:0] code; logic lsb; logic [15:0] tx, pat;} ssu_row_t;
    localparam logic [31:0] adr_mc = `SSU_ADDR_MAIN_CTL;
    localparam logic [31:0] adr_ck = `SSU_ADDR_CLK_CTL;
    localparam logic [31:0] adr_ln = `SSU_ADDR_LEN_CTL;
    localparam logic [31:0] adr_st = `SSU_ADDR_STATUS;
    localparam logic [31:0] adr_tx = `SSU_ADDR_TX_DATA;
    localparam logic [31:0] adr_rx = `SSU_ADDR_RX_DATA;
    logic [31:0] regs[4] = '{adr_mc, adr_ck, adr_ln, adr_st};
    ssu_row_t rows[6] = '{'{4'h0, 1'b0, 16'hffa5, 16'hb5c3}, '{4'h1, 1'b1, 16'hfe6d, 16'h9e37},
        '{4'h7, 1'b0, 16'h8421, 16'h5aa5}, '{4'h8, 1'b1, 16'hc0f3, 16'h3cc3},
        '{4'hf, 1'b0, 16'h1e2d, 16'he718}, '{4'h3, 1'b1, 16'hf0f0, 16'h0ff1}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, d;
    logic pready, pslverr, sck, sout, sin, rc_irq, tr_irq, serr;
    logic pclr = 1'b0;
    logic rx_only = 1'b0;
    logic sout_hi = 1'b0;
    logic [15:0] ppat = 16'h0;
    logic [15:0] pgot;
    int err_total = 0;
    int compares = 0;
    int rc_cnt = 0;
    int tr_cnt = 0;
    always #25 pclk = ~pclk;
    ssu_top ssu_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .shift_clock_pin(sck), .serial_out_pin(sout),
        .serial_in_pin(sin), .receive_complete_irq(rc_irq), .transmit_ready_irq(tr_irq));
    ssu_peer ssu_peer_i (.pclk(pclk), .sck(sck), .sout(sout), .clr(pclr), .pat(ppat),
        .sin(sin), .got(pgot));
    always @(posedge pclk) begin
        if (rc_irq === 1'b1) rc_cnt++;
        if (tr_irq === 1'b1) tr_cnt++;
        if (rx_only && sout !== 1'b0) sout_hi = 1'b1;
    end
    task automatic print_verdict();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(d, e);
    endtask
    task automatic wait_idle();
        do apb(1'b0, adr_st, 32'h0); while (d[`SSU_ST_BUSY] !== 1'b0);
    endtask
    function automatic logic [15:0] rev(input logic [15:0] v, input int n);
        logic [15:0] r;
        r = 16'h0;
        for (int i = 0; i < n; i++) r[i] = v[n - 1 - i];
        return r;
    endfunction
    initial begin
        repeat (40000) @(posedge pclk);
        err_total++;
        print_verdict();
    end
    initial begin
        ssu_row_t r;
        int n, n0;
        logic [15:0] m, v;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wr(adr_ck, 32'h3);
        foreach (rows[i]) begin
            r = rows[i];
            n = r.code[3] ? 16 : 8 + r.code[2:0];
            m = 16'((32'h1 << n) - 32'h1);
            wr(adr_mc, 32'h0);
            wr(adr_ln, {28'h0, r.code});
            rdchk(adr_ln, {28'h0, r.code});
            wr(adr_mc, 32'he0 | {27'h0, r.lsb, 4'h0});
            ppat <= r.pat;
            pclr <= 1'b1;
            @(posedge pclk);
            pclr <= 1'b0;
            n0 = rc_cnt;
            wr(adr_tx, {16'h0, r.tx});
            rdchk(adr_st, 32'h80);
            wait_idle();
            chk(rc_cnt - n0, 1);
            v = r.tx & m;
            chk(pgot & m, r.lsb ? rev(v, n) : v);
            v = r.pat >> (16 - n);
            rdchk(adr_rx, r.lsb ? rev(v, n) : v);
            rdchk(adr_st, 32'h0);
        end
        chk(tr_cnt, 0);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) rdchk(regs[i], 32'h0);
        wr(adr_ck, 32'h3);
        apb(1'b0, 32'h0, 32'h0);
        chk(serr, 1);
        chk(d, 0);
        wr(adr_mc, 32'he0);
        wr(adr_ln, 32'h5);
        rdchk(adr_ln, 32'h0);
        wr(adr_mc, 32'h0);
        wr(adr_mc, 32'hc0);
        n0 = rc_cnt;
        repeat (2) begin
            wr(adr_tx, 32'ha5);
            wait_idle();
        end
        chk(rc_cnt - n0, 2);
        rdchk(adr_st, 32'h1);
        wr(adr_st, 32'h81);
        rdchk(adr_st, 32'h1);
        wr(adr_st, 32'h0);
        rdchk(adr_st, 32'h0);
        wr(adr_tx, 32'h5a);
        wr(adr_mc, 32'h0);
        rdchk(adr_st, 32'h0);
        repeat (50) @(posedge pclk);
        ppat <= 16'hc3a5;
        pclr <= 1'b1;
        rx_only <= 1'b1;
        @(posedge pclk);
        pclr <= 1'b0;
        wr(adr_mc, 32'ha1);
        apb(1'b0, adr_rx, 32'h0);
        rdchk(adr_st, 32'h80);
        wait_idle();
        rdchk(adr_rx, 32'hc3);
        rdchk(adr_st, 32'h80);
        wait_idle();
        wr(adr_mc, 32'ha0);
        rdchk(adr_rx, 32'ha5);
        rdchk(adr_st, 32'h0);
        chk(sout_hi, 0);
        rx_only <= 1'b0;
        wr(adr_mc, 32'h0);
        wr(adr_mc, 32'hc2);
        wr(adr_tx, 32'h81);
        wr(adr_tx, 32'h42);
        wait_idle();
        chk(tr_cnt, 2);
        print_verdict();
    end
endmodule
bind ssu_top ssu_top_sva ssu_top_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clock_pin(shift_clock_pin), .serial_out_pin(serial_out_pin),
    .receive_complete_irq(receive_complete_irq), .transmit_ready_irq(transmit_ready_irq));
